// ### design/pcc_pkg.sv
// constants for the bus command and status register bank
package pcc_pkg;

  // ****************************************************************
  // register offsets (byte address in configuration space)
  // ****************************************************************
  localparam logic [7:0]  CMD_OFFSET     = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h06;
  localparam logic [7:0]  EXT_NINE_OFFSET = 8'h40;

  // ****************************************************************
  // command register layout
  // ****************************************************************
  localparam logic [15:0] CMD_RESET      = 16'h00A0;
  localparam logic [15:0] CMD_WR_MASK    = 16'h02A0;
  localparam int          CMD_PALETTE_BIT = 5;
  localparam int          CMD_STEP_BIT   = 7;
  localparam int          CMD_B2B_BIT    = 9;

  // ****************************************************************
  // status register layout
  // ****************************************************************
  localparam int          STAT_FB2B_BIT  = 7;
  localparam int          STAT_DEVSEL_LO = 9;
  localparam int          STAT_TABORT_BIT = 11;
  localparam int          STAT_MABORT_BIT = 12;
  localparam logic [1:0]  DEVSEL_FAST    = 2'h0;
  localparam logic [1:0]  DEVSEL_MEDIUM  = 2'h1;
  localparam logic [1:0]  DEVSEL_SLOW    = 2'h2;

  // ****************************************************************
  // sticky flags and strap synchroniser
  // ****************************************************************
  localparam int          NUM_FLAGS      = 2;
  localparam int          FLAG_TABORT    = 0;
  localparam int          FLAG_MABORT    = 1;
  localparam int          STRAP_STAGES   = 3;

endpackage : pcc_pkg

// ### design/pcc_flag_if.sv
// interface between the register bank and its sticky flag cells
`timescale 1ns/1ps
interface pcc_flag_if;
  logic [1:0] setPulse;
  logic [1:0] clearMask;
  logic [1:0] flagState;

  modport owner (
    input  setPulse,
    input  clearMask,
    output flagState
  );
  modport user (
    output setPulse,
    output clearMask,
    input  flagState
  );
endinterface : pcc_flag_if

// ### design/pcc_w1c_flags.sv
// sticky write-one-to-clear flag cells
`timescale 1ns/1ps
module pcc_w1c_flags
  import pcc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic clkEn,
  // flags
  pcc_flag_if.owner flags
);

  logic [NUM_FLAGS-1:0] flag_reg;
  logic [NUM_FLAGS-1:0] flag_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : gFlag
      // a set in the clearing cycle wins so no event is lost
      always_comb begin
        flag_next[gi] = flags.setPulse[gi] |
                        (flag_reg[gi] & ~flags.clearMask[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_reg <= '0;
    end else if (clkEn) begin
      flag_reg <= flag_next;
    end
  end

  assign flags.flagState = flag_reg;

  property p_setWins;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && flags.setPulse[0]) |=> flag_reg[0];
  endproperty
  a_setWins: assert property (p_setWins)
    else $error("flag set lost against clear");

endmodule : pcc_w1c_flags

// ### design/pcc_cmd_status.sv
// bus command and status register bank with strap capture
`timescale 1ns/1ps
module pcc_cmd_status
  import pcc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // configuration access port
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [1:0]  cfgByteEn,
  input  wire logic [15:0] cfgWrData,
  output logic      [15:0] cfgRdData,
  output logic             cfgRdValid,
  // master engine events
  input  wire logic        targetAbortSeen,
  input  wire logic        masterAbortSeen,
  // strap pin
  input  wire logic        memoryDataStrapSixteen,
  // controls to the bus engines
  output logic             steppingEnable,
  output logic             backToBackEnable,
  output logic             paletteClaimEn,
  output logic [1:0]       devselTiming,
  output logic             extRegNineBit0
);

  // ****************************************************************
  // strap synchroniser and capture
  // ****************************************************************
  // the chain is not reset: it must keep sampling the pin while
  // reset is held, otherwise nothing would be caught
  logic [STRAP_STAGES-1:0] strapSync_reg;
  logic [STRAP_STAGES-1:0] strapSync_next;
  logic                    strapFilt_reg;
  logic                    strapFilt_next;
  logic                    strapHeld_reg;
  logic                    strapHeld_next;

  always_comb begin
    strapSync_next = {strapSync_reg[STRAP_STAGES-2:0],
                      memoryDataStrapSixteen};
    strapFilt_next = strapFilt_reg;
    if (strapSync_reg[1] == strapSync_reg[2]) begin
      strapFilt_next = strapSync_reg[2];
    end
    strapHeld_next = strapHeld_reg;
    if (srst) begin
      strapHeld_next = strapFilt_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      strapSync_reg <= strapSync_next;
      strapFilt_reg <= strapFilt_next;
      strapHeld_reg <= strapHeld_next;
    end
  end

  // ****************************************************************
  // command register
  // ****************************************************************
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [15:0] laneMask;
  logic        cmdHit;
  logic        statusHit;
  logic        extHit;

  always_comb begin
    laneMask  = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};
    cmdHit    = (cfgAddr == CMD_OFFSET);
    statusHit = (cfgAddr == STATUS_OFFSET);
    extHit    = (cfgAddr == EXT_NINE_OFFSET);
    cmd_next  = cmd_reg;
    if (cfgWrite && cmdHit) begin
      // only bits 5, 7 and 9 take a write, the rest stay zero
      cmd_next = (cmd_reg & ~(CMD_WR_MASK & laneMask)) |
                 (cfgWrData & CMD_WR_MASK & laneMask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_reg <= CMD_RESET;
    end else if (clkEn) begin
      cmd_reg <= cmd_next;
    end
  end

  // ****************************************************************
  // status register
  // ****************************************************************
  pcc_flag_if flagBus ();

  pcc_w1c_flags uFlags (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clkEn   (clkEn),
    .flags   (flagBus.owner)
  );

  logic [15:0] statusWord;
  logic [1:0]  devselCode;
  logic        statusWrHi;

  always_comb begin
    devselCode = strapHeld_reg ? DEVSEL_SLOW : DEVSEL_MEDIUM;
    statusWrHi = cfgWrite && statusHit && cfgByteEn[1];
    flagBus.setPulse[FLAG_TABORT] = targetAbortSeen;
    flagBus.setPulse[FLAG_MABORT] = masterAbortSeen;
    // a one clears, a zero leaves the flag alone
    flagBus.clearMask[FLAG_TABORT] =
      statusWrHi && cfgWrData[STAT_TABORT_BIT];
    flagBus.clearMask[FLAG_MABORT] =
      statusWrHi && cfgWrData[STAT_MABORT_BIT];
    statusWord = 16'h0000;
    statusWord[STAT_FB2B_BIT] = 1'b1;
    statusWord[STAT_DEVSEL_LO +: 2] = devselCode;
    statusWord[STAT_TABORT_BIT] = flagBus.flagState[FLAG_TABORT];
    statusWord[STAT_MABORT_BIT] = flagBus.flagState[FLAG_MABORT];
  end

  // ****************************************************************
  // read path and control outputs
  // ****************************************************************
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic        rdValid_reg;
  logic        rdValid_next;
  logic        step_reg;
  logic        step_next;
  logic        b2b_reg;
  logic        b2b_next;
  logic        palClaim_reg;
  logic        palClaim_next;
  logic [1:0]  devsel_reg;
  logic [1:0]  devsel_next;
  logic        extNine_reg;
  logic        extNine_next;

  always_comb begin
    rdValid_next = cfgRead;
    rdData_next  = 16'h0000;
    if (cfgRead) begin
      if (cmdHit) begin
        rdData_next = cmd_reg & laneMask;
      end else if (statusHit) begin
        rdData_next = statusWord & laneMask;
      end else if (extHit) begin
        rdData_next = {15'h0000, strapHeld_reg} & laneMask;
      end
    end
    step_next     = cmd_next[CMD_STEP_BIT];
    b2b_next      = cmd_next[CMD_B2B_BIT];
    palClaim_next = ~cmd_next[CMD_PALETTE_BIT];
    devsel_next   = devselCode;
    extNine_next  = strapHeld_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_reg   <= 16'h0000;
      rdValid_reg  <= 1'b0;
      step_reg     <= CMD_RESET[CMD_STEP_BIT];
      b2b_reg      <= CMD_RESET[CMD_B2B_BIT];
      palClaim_reg <= ~CMD_RESET[CMD_PALETTE_BIT];
      devsel_reg   <= DEVSEL_MEDIUM;
      extNine_reg  <= 1'b0;
    end else if (clkEn) begin
      rdData_reg   <= rdData_next;
      rdValid_reg  <= rdValid_next;
      step_reg     <= step_next;
      b2b_reg      <= b2b_next;
      palClaim_reg <= palClaim_next;
      devsel_reg   <= devsel_next;
      extNine_reg  <= extNine_next;
    end
  end

  always_comb begin
    cfgRdData        = rdData_reg;
    cfgRdValid       = rdValid_reg;
    steppingEnable   = step_reg;
    backToBackEnable = b2b_reg;
    paletteClaimEn   = palClaim_reg;
    devselTiming     = devsel_reg;
    extRegNineBit0   = extNine_reg;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_stepWrite;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && cfgWrite && cmdHit && cfgByteEn[0])
        |=> steppingEnable == $past(cfgWrData[CMD_STEP_BIT]);
  endproperty
  a_stepWrite: assert property (p_stepWrite)
    else $error("stepping enable does not follow command write");

  property p_b2bWrite;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && cfgWrite && cmdHit && cfgByteEn[1])
        |=> backToBackEnable == $past(cfgWrData[CMD_B2B_BIT]);
  endproperty
  a_b2bWrite: assert property (p_b2bWrite)
    else $error("back-to-back enable does not follow command write");

  property p_cmdReset;
    @(posedge clk_sys)
      $fell(srst) |-> (cmd_reg == CMD_RESET) && steppingEnable &&
                      !backToBackEnable;
  endproperty
  a_cmdReset: assert property (p_cmdReset)
    else $error("command register not at default after reset");

  property p_noSwSet;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && !targetAbortSeen && !statusWord[STAT_TABORT_BIT])
        |=> !statusWord[STAT_TABORT_BIT];
  endproperty
  a_noSwSet: assert property (p_noSwSet)
    else $error("target abort flag set without an event");

  property p_statusRead;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && cfgRead && statusHit && cfgByteEn == 2'h3)
        |=> cfgRdValid && cfgRdData == $past(statusWord);
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status read returned wrong contents");

  property p_fb2bOne;
    @(posedge clk_sys) disable iff (srst)
      statusWord[STAT_FB2B_BIT] && statusWord[6:0] == 7'h00 &&
      !statusWord[8] && cmd_reg[15:10] == 6'h00;
  endproperty
  a_fb2bOne: assert property (p_fb2bOne)
    else $error("fixed or reserved status bits wrong");

  property p_devsel;
    @(posedge clk_sys) disable iff (srst)
      ##1 devselTiming == (extRegNineBit0 ? DEVSEL_SLOW : DEVSEL_MEDIUM)
        || !$past(clkEn);
  endproperty
  a_devsel: assert property (p_devsel)
    else $error("devsel timing disagrees with captured strap");

  property p_tabort;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && targetAbortSeen) |=> statusWord[STAT_TABORT_BIT];
  endproperty
  a_tabort: assert property (p_tabort)
    else $error("target abort not recorded");

  property p_mabort;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && masterAbortSeen) |=> statusWord[STAT_MABORT_BIT]
        ##1 (statusWord[STAT_MABORT_BIT] || $past(statusWrHi));
  endproperty
  a_mabort: assert property (p_mabort)
    else $error("master abort flag not held");

  property p_palette;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && cfgWrite && cmdHit && cfgByteEn[0])
        |=> paletteClaimEn != $past(cfgWrData[CMD_PALETTE_BIT]);
  endproperty
  a_palette: assert property (p_palette)
    else $error("palette claim does not follow command bit 5");

  property p_tabortClear;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && statusWrHi && cfgWrData[STAT_TABORT_BIT] &&
       !targetAbortSeen) |=> !statusWord[STAT_TABORT_BIT];
  endproperty
  a_tabortClear: assert property (p_tabortClear)
    else $error("target abort flag not cleared by a one");

  property p_unmapped;
    @(posedge clk_sys) disable iff (srst)
      (clkEn && cfgRead && !cmdHit && !statusHit && !extHit)
        |=> cfgRdValid && cfgRdData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned nonzero data");

  property p_ctlFreeze;
    @(posedge clk_sys) disable iff (srst)
      !clkEn |=> $stable(steppingEnable) && $stable(backToBackEnable) &&
                 $stable(paletteClaimEn) && $stable(cfgRdValid);
  endproperty
  a_ctlFreeze: assert property (p_ctlFreeze)
    else $error("controls moved while the clock enable was low");

  // the captured strap may only move on the first edge after reset
  property p_strapStill;
    @(posedge clk_sys) disable iff (srst)
      ($changed(extRegNineBit0) || $changed(devselTiming))
        |-> $past(srst, 2);
  endproperty
  a_strapStill: assert property (p_strapStill)
    else $error("captured strap changed outside reset");

endmodule : pcc_cmd_status

// ### bench/pcc_master_model.sv
// behavioural bus master engine that reports abort events
`timescale 1ns/1ps
module pcc_master_model (
  // clock
  input  wire logic       clk_sys,
  // abort requests from the bench: [0] target, [1] master
  input  wire logic [1:0] abortReq,
  // abort events towards the register bank
  output logic            targetAbortSeen,
  output logic            masterAbortSeen
);
  // one-cycle pulses, exactly as the bus engine would report them
  always @(posedge clk_sys) begin
    targetAbortSeen <= abortReq[0];
    masterAbortSeen <= abortReq[1];
  end
endmodule : pcc_master_model

// ### bench/tb_top.sv
// self-checking testbench for the command and status register bank
`timescale 1ns/1ps
module tb_top;
  import pcc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        clkEn   = 1'b1;
  logic        cfgWrite = 1'b0;
  logic        cfgRead  = 1'b0;
  logic [7:0]  cfgAddr  = 8'h00;
  logic [1:0]  cfgByteEn = 2'h0;
  logic [15:0] cfgWrData = 16'h0000;
  logic [1:0]  abortReq = 2'h0;
  logic        strap    = 1'b0;
  logic [15:0] cfgRdData;
  logic        cfgRdValid;
  logic        targetAbortSeen;
  logic        masterAbortSeen;
  logic        stepEn, b2bEn, palEn, extBit;
  logic [1:0]  devsel;
  logic [15:0] outVec;
  logic [15:0] rdv;
  int          miscompares = 0;
  int          samples_checked = 0;

  assign outVec = {10'h000, extBit, stepEn, b2bEn, palEn, devsel};
  always #10 clk_sys = ~clk_sys;

  pcc_cmd_status dut_u (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .targetAbortSeen(targetAbortSeen),
    .masterAbortSeen(masterAbortSeen), .memoryDataStrapSixteen(strap),
    .steppingEnable(stepEn), .backToBackEnable(b2bEn),
    .paletteClaimEn(palEn), .devselTiming(devsel), .extRegNineBit0(extBit));

  pcc_master_model partner_u (.clk_sys(clk_sys), .abortReq(abortReq),
    .targetAbortSeen(targetAbortSeen), .masterAbortSeen(masterAbortSeen));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge clk_sys);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWrData <= d;
    @(posedge clk_sys);
    cfgWrite <= 1'b0;
    @(negedge clk_sys);
  endtask : wr

  // waits a bounded number of cycles for the read answer
  task automatic rd(input logic [7:0] a, input logic [1:0] be,
                    output logic [15:0] d);
    int n;
    @(posedge clk_sys);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    cfgByteEn <= be;
    @(posedge clk_sys);
    cfgRead <= 1'b0;
    d = 16'hDEAD;
    for (n = 0; n < 4; n++) begin
      @(negedge clk_sys);
      if (cfgRdValid === 1'b1) begin
        d = cfgRdData;
        break;
      end
    end
    if (n == 4) begin
      miscompares++;
      tally_and_finish();
    end
    @(negedge clk_sys);
    chk({n[14:0], cfgRdValid}, 16'h0000);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [1:0] be,
                       input logic [15:0] exp);
    rd(a, be, rdv);
    chk(rdv, exp);
  endtask : rdchk

  // strap must be steady through the whole reset
  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    strap <= s;
    srst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : do_reset

  task automatic abort(input logic [1:0] k);
    @(posedge clk_sys);
    abortReq <= k;
    @(posedge clk_sys);
    abortReq <= 2'h0;
    repeat (2) @(posedge clk_sys);
  endtask : abort

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    do_reset(1'b0);
    chk(outVec, 16'h0011);
    rdchk(CMD_OFFSET, 2'h3, 16'h00A0);
    rdchk(STATUS_OFFSET, 2'h3, 16'h0280);
    rdchk(STATUS_OFFSET, 2'h1, 16'h0080);
    rdchk(EXT_NINE_OFFSET, 2'h3, 16'h0000);
    rdchk(8'h08, 2'h3, 16'h0000);
    wr(CMD_OFFSET, 2'h3, 16'hFFFF);
    chk(outVec, 16'h0019);
    rdchk(CMD_OFFSET, 2'h3, 16'h02A0);
    wr(CMD_OFFSET, 2'h3, 16'h0000);
    chk(outVec, 16'h0005);
    wr(CMD_OFFSET, 2'h1, 16'h0200);
    rdchk(CMD_OFFSET, 2'h3, 16'h0000);
    wr(CMD_OFFSET, 2'h2, 16'h0280);
    rdchk(CMD_OFFSET, 2'h3, 16'h0200);
    wr(STATUS_OFFSET, 2'h3, 16'hFFFF);
    rdchk(STATUS_OFFSET, 2'h3, 16'h0280);
    abort(2'h1);
    rdchk(STATUS_OFFSET, 2'h3, 16'h0A80);
    abort(2'h2);
    rdchk(STATUS_OFFSET, 2'h3, 16'h1A80);
    wr(STATUS_OFFSET, 2'h2, 16'h0800);
    rdchk(STATUS_OFFSET, 2'h3, 16'h1280);
    wr(STATUS_OFFSET, 2'h1, 16'h1000);
    rdchk(STATUS_OFFSET, 2'h3, 16'h1280);
    wr(STATUS_OFFSET, 2'h3, 16'h1000);
    rdchk(STATUS_OFFSET, 2'h3, 16'h0280);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(CMD_OFFSET, 2'h3, 16'h00A0);
    chk(outVec, 16'h000D);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    rdchk(CMD_OFFSET, 2'h3, 16'h0200);
    do_reset(1'b1);
    chk(outVec, 16'h0032);
    rdchk(STATUS_OFFSET, 2'h3, 16'h0480);
    rdchk(EXT_NINE_OFFSET, 2'h3, 16'h0001);
    rdchk(CMD_OFFSET, 2'h3, 16'h00A0);
    tally_and_finish();
  end
endmodule : tb_top
